// ===== logic/ref_temp_pkg.sv
package ref_temp_pkg;

  // Register map and data width
  localparam int unsigned DATA_W              = 32;
  localparam int unsigned ADDR_W              = 8;
  localparam int unsigned REG_W               = 8;
  localparam logic [7:0]  CONTROL_OFFSET      = 8'h00;
  localparam logic [7:0]  GAIN_STATUS_OFFSET  = 8'h04;

  // Field positions of the control register
  localparam int unsigned REF_EN_BIT          = 7;
  localparam int unsigned READY_BIT           = 6;
  localparam int unsigned TS_EN_BIT           = 5;
  localparam int unsigned TS_RANGE_BIT        = 4;
  localparam int unsigned CMP_GAIN_LSB        = 2;
  localparam int unsigned ADC_GAIN_LSB        = 0;
  localparam int unsigned GAIN_W              = 2;

  // Reset value of every writable field, and the fixed ready level
  localparam logic [7:0]  CONTROL_RESET       = 8'h00;
  localparam logic        READY_VALUE         = 1'b1;

  // Gain field encodings
  localparam logic [1:0]  GAIN_OFF            = 2'h0;
  localparam logic [1:0]  GAIN_X1             = 2'h1;
  localparam logic [1:0]  GAIN_X2             = 2'h2;
  localparam logic [1:0]  GAIN_X4             = 2'h3;

  // One-hot buffer selects: bit 0 = 1x, bit 1 = 2x, bit 2 = 4x
  localparam int unsigned SEL_W               = 3;
  localparam logic [2:0]  SEL_NONE            = 3'h0;
  localparam logic [2:0]  SEL_X1              = 3'h1;
  localparam logic [2:0]  SEL_X2              = 3'h2;
  localparam logic [2:0]  SEL_X4              = 3'h4;

endpackage

// ===== logic/gain_decode.sv
`timescale 1ns/1ps
module gain_decode (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Gain code from the register
  input  wire logic [ref_temp_pkg::GAIN_W-1:0] gain_code_i,
  // Buffer controls
  output logic                                 buffer_on_o,
  output logic      [ref_temp_pkg::SEL_W-1:0]  gain_sel_o
);
  import ref_temp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Registered decode so the analog side never sees a decoding glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_on_o <= 1'b0;
      gain_sel_o  <= SEL_NONE;
    end else begin
      buffer_on_o <= (gain_code_i != GAIN_OFF);
      unique case (gain_code_i)
        GAIN_X4: gain_sel_o <= SEL_X4;
        GAIN_X2: gain_sel_o <= SEL_X2;
        GAIN_X1: gain_sel_o <= SEL_X1;
        GAIN_OFF: gain_sel_o <= SEL_NONE;
      endcase
    end
  end

endmodule // gain_decode

// ===== logic/wb_byte_reg.sv
`timescale 1ns/1ps
module wb_byte_reg
  import ref_temp_pkg::*;
#(
  parameter int unsigned WIDTH            = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] WRITE_MASK  = '1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Write strobe and data
  input  wire logic             write_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // Stored value
  output logic [WIDTH-1:0]      value_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Only masked bits take write data; the rest keep their reset value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
    end else if (write_i) begin
      value_o <= (wdata_i & WRITE_MASK) | (value_o & ~WRITE_MASK);
    end
  end

endmodule // wb_byte_reg

// ===== logic/reference_and_temp_sense_control.sv
`timescale 1ns/1ps
// What this block does
// - Bit 7 enables the voltage reference; 1 on, 0 off.
// - Bit 6 is a read-only ready flag that always reads one.
// - Bit 5 enables the temperature indicator; 1 on, 0 off.
// - Bit 4 selects temperature range; 1 high (three drops), 0 low.
// - Bits 3-2 comparator gain: 11 4x, 10 2x, 01 1x, 00 off.
// - Bits 1-0 converter gain: same encoding as the comparator field.
// - All writable fields clear to zero on every reset.
module reference_and_temp_sense_control (
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // Wishbone classic slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [ref_temp_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [ref_temp_pkg::DATA_W-1:0] dat_i,
  output logic      [ref_temp_pkg::DATA_W-1:0] dat_o,
  output logic                                ack_o,
  output logic                                err_o,
  // Reference controls
  output logic                                reference_enable_o,
  output logic                                temp_sense_enable_o,
  output logic                                temp_range_select_o,
  output logic      [ref_temp_pkg::GAIN_W-1:0] comparator_ref_gain_o,
  output logic      [ref_temp_pkg::GAIN_W-1:0] converter_ref_gain_o,
  // Decoded buffer controls
  output logic                                comparator_buffer_on_o,
  output logic      [ref_temp_pkg::SEL_W-1:0]  comparator_gain_sel_o,
  output logic                                converter_buffer_on_o,
  output logic      [ref_temp_pkg::SEL_W-1:0]  converter_gain_sel_o
);
  import ref_temp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Local constants

  // Writable bits; the ready bit is excluded so writes cannot touch it
  localparam logic [REG_W-1:0] WRITE_MASK = ~(REG_W'(1) << READY_BIT);
  // Zero fill above the register byte on the data bus
  localparam int unsigned      FILL_W     = DATA_W - REG_W;
  // Byte lane that carries the register
  localparam int unsigned      LANE       = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Exact match of the byte address against one register slot
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] adr,
    input logic [ADDR_W-1:0] offset
  );
    return (adr == offset);
  endfunction

  // Control byte as software sees it; ready is fixed, not stored
  function automatic logic [REG_W-1:0] control_view(
    input logic [REG_W-1:0] stored
  );
    logic [REG_W-1:0] view;
    view            = stored;
    view[READY_BIT] = READY_VALUE;
    return view;
  endfunction

  // One decoded path: buffer-on flag above its one-hot select
  function automatic logic [SEL_W:0] pack_path(
    input logic             on,
    input logic [SEL_W-1:0] sel
  );
    return {on, sel};
  endfunction

  // Zero-extend one register byte onto the data bus; upper lanes read zero
  function automatic logic [DATA_W-1:0] to_bus(
    input logic [REG_W-1:0] value
  );
    return {{FILL_W{1'b0}}, value};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Internal signals

  // Bus qualification
  logic             bus_cycle;
  logic             req;
  logic             hit_control;
  logic             hit_status;
  logic             hit_any;
  // Write and read intent
  logic             write_lane;
  logic             control_write;
  logic             read_control;
  logic             read_status;
  // Stored and visible register contents
  logic [REG_W-1:0] control;
  logic [REG_W-1:0] read_view;
  logic [REG_W-1:0] status_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Master is asking for a transfer
  assign bus_cycle     = cyc_i & stb_i;
  // New request only while no answer stands, so one answer per request
  assign req           = bus_cycle & ~ack_o & ~err_o;
  // Address decode, shared by the answer and the read data
  assign hit_control   = addr_hit(adr_i, CONTROL_OFFSET);
  assign hit_status    = addr_hit(adr_i, GAIN_STATUS_OFFSET);
  assign hit_any       = hit_control | hit_status;
  // Only byte lane 0 carries the register; other lanes are ignored
  assign write_lane    = sel_i[LANE];
  // Commit where the master sees ack, its request still held
  assign control_write = bus_cycle & we_i & ack_o & hit_control & write_lane;
  // Read requests per slot, taken on the request edge
  assign read_control  = req & ~we_i & hit_control;
  assign read_status   = req & ~we_i & hit_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register storage
  wb_byte_reg #(
    .WIDTH       (REG_W),
    .RESET_VALUE (CONTROL_RESET),
    .WRITE_MASK  (WRITE_MASK)
  ) u_control (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .write_i (control_write),
    .wdata_i (dat_i[REG_W-1:0]),
    .value_o (control)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read views: ready forced to one, status packs both decoded paths
  assign read_view   = control_view(control);
  assign status_view = {pack_path(converter_buffer_on_o, converter_gain_sel_o),
                        pack_path(comparator_buffer_on_o, comparator_gain_sel_o)};

  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge one cycle after a request to a mapped slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & hit_any;
    end
  end

  // Unmapped slots answer with an error and change nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= req & ~hit_any;
    end
  end

  // Read data registered with the ack; zero whenever no read answer stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (read_control) begin
      dat_o <= to_bus(read_view);
    end else if (read_status) begin
      dat_o <= to_bus(status_view);
    end else begin
      dat_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field outputs straight from the stored register
  assign reference_enable_o    = control[REF_EN_BIT];
  assign temp_sense_enable_o   = control[TS_EN_BIT];
  assign temp_range_select_o   = control[TS_RANGE_BIT];
  assign comparator_ref_gain_o = control[CMP_GAIN_LSB +: GAIN_W];
  assign converter_ref_gain_o  = control[ADC_GAIN_LSB +: GAIN_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer decoders, one per path
  gain_decode u_cmp_decode (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .gain_code_i (comparator_ref_gain_o),
    .buffer_on_o (comparator_buffer_on_o),
    .gain_sel_o  (comparator_gain_sel_o)
  );

  gain_decode u_adc_decode (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .gain_code_i (converter_ref_gain_o),
    .buffer_on_o (converter_buffer_on_o),
    .gain_sel_o  (converter_gain_sel_o)
  );

endmodule // reference_and_temp_sense_control

// ===== test/ref_temp_asserts.sv
`timescale 1ns/1ps
module ref_temp_asserts (
  // Bus side
  input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i, dat_o,
  // Field side
  input wire logic        reference_enable_o, temp_sense_enable_o, temp_range_select_o,
  input wire logic [1:0]  comparator_ref_gain_o, converter_ref_gain_o,
  input wire logic        comparator_buffer_on_o,
  input wire logic [2:0]  converter_gain_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Control write committed at this edge, where the master sees ack
  logic       wr;
  logic [6:0] f;
  assign wr = cyc_i && stb_i && we_i && adr_i == 8'h00 && sel_i[0] && ack_o;
  assign f = {reference_enable_o, temp_sense_enable_o, temp_range_select_o,
              comparator_ref_gain_o, converter_ref_gain_o};
  property p_ref; wr |=> reference_enable_o == $past(dat_i[7]); endproperty
  a_ref: assert property (p_ref) else $error("enable missed write");
  property p_rdy; ack_o && !$past(we_i) && $past(adr_i) == 8'h00
    |-> dat_o[7:0] == {f[6], 1'b1, f[5:0]}; endproperty
  a_rdy: assert property (p_rdy) else $error("bad control read");
  property p_ts; wr |=> temp_sense_enable_o == $past(dat_i[5]); endproperty
  a_ts: assert property (p_ts) else $error("sense enable missed write");
  property p_rng; wr |=> temp_range_select_o == $past(dat_i[4]); endproperty
  a_rng: assert property (p_rng) else $error("range missed write");
  property p_cmp; wr |=> comparator_ref_gain_o == $past(dat_i[3:2])
    ##1 comparator_buffer_on_o == ($past(comparator_ref_gain_o) != 2'h0); endproperty
  a_cmp: assert property (p_cmp) else $error("comparator gain wrong");
  property p_conv; converter_gain_sel_o == {$past(converter_ref_gain_o) == 2'h3,
    $past(converter_ref_gain_o) == 2'h2, $past(converter_ref_gain_o) == 2'h1}; endproperty
  a_conv: assert property (p_conv) else $error("converter select wrong");
  property p_rst; $past(rst_i) |-> f == 7'h00; endproperty
  a_rst: assert property (p_rst) else $error("fields not cleared");
  property p_hold; !wr |=> $stable(f); endproperty
  a_hold: assert property (p_hold) else $error("field moved without write");
  property p_ack; cyc_i && stb_i && !ack_o && !err_o |=> ack_o != err_o; endproperty
  a_ack: assert property (p_ack) else $error("no single answer");
  c_wr: cover property (wr);
  c_rd: cover property (ack_o && !we_i);
  c_err: cover property (err_o);
endmodule // ref_temp_asserts
bind reference_and_temp_sense_control ref_temp_asserts ref_temp_asserts_i (.*);

// ===== test/reference_and_temp_sense_control_test.sv
`timescale 1ns/1ps
module reference_and_temp_sense_control_test;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = '0, d, ctl;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic        ack_o, err_o, reference_enable_o, temp_sense_enable_o, temp_range_select_o;
  logic [1:0]  comparator_ref_gain_o, converter_ref_gain_o;
  logic        comparator_buffer_on_o, converter_buffer_on_o;
  logic [2:0]  comparator_gain_sel_o, converter_gain_sel_o;
  logic [8:0]  q[$], note;
  int          n_fail = 0, n_checks = 0;
  reference_and_temp_sense_control reference_and_temp_sense_control_i (.*);
  always #5 clk_i = ~clk_i;
  // Bus answer: error flag above the full read word
  task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: bus got %h want %h", $time, got, exp);
    end
  endtask
  // Field and decoded outputs toward the analog side
  task automatic chk_fields(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: fields got %h want %h", $time, got, exp);
    end
  endtask
  // Classic cycle held until answer; bench watchdog bounds the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, v};
    do @(posedge clk_i); while (!(ack_o | err_o));
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    q.push_back(exp);
    wb(0, a, 4'hf, '0);
  endtask
  function automatic logic [3:0] dec(input logic [1:0] g);
    return {g != 2'h0, g == 2'h3, g == 2'h2, g == 2'h1};
  endfunction
  // Watcher takes the oldest note on each read answer or error
  always @(posedge clk_i) if ((ack_o && !we_i) || err_o) begin
    note = q.pop_front();
    chk_bus({err_o, ack_o ? dat_o : 32'h0}, {note[8], 24'h0, note[7:0]});
    if (ack_o && adr_i == 8'h00) chk_fields({2'b0, reference_enable_o, temp_sense_enable_o,
      temp_range_select_o, comparator_ref_gain_o, converter_ref_gain_o},
      {2'b0, note[7], note[5:0]});
    if (ack_o && adr_i == 8'h04) chk_fields({1'b0, converter_buffer_on_o,
      converter_gain_sel_o, comparator_buffer_on_o, comparator_gain_sel_o}, note);
  end
  task automatic tally_and_finish;
    if (q.size() != 0) n_fail++; // Notes left without an answer
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hf439));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h00, 9'h040);
    $display("reset value test done");
    // Every gain pair, random upper bits and lanes
    for (int i = 0; i < 16; i++) begin
      d = (8'($urandom) & 8'hf0) | 8'(i);
      ctl = d & 8'hbf;
      wb(1, 8'h00, 4'($urandom) | 4'h1, {24'($urandom), d});
      rd(8'h00, {1'b0, ctl | 8'h40});
      rd(8'h04, {1'b0, dec(ctl[1:0]), dec(ctl[3:2])});
    end
    $display("field decode test done");
    // Writes that must change nothing, then unmapped places
    wb(1, 8'h00, 4'he, 32'h0000_00ff);
    wb(1, 8'h04, 4'hf, 32'h0000_0000);
    rd(8'h00, {1'b0, ctl | 8'h40});
    rd(8'h08, 9'h100);
    q.push_back(9'h100);
    wb(1, 8'h08, 4'hf, 32'hffff_ffff);
    $display("refusal test done");
    wb(1, 8'h00, 4'h1, 32'h0000_00bf);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h00, 9'h040);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule // reference_and_temp_sense_control_test
